// File: tsm_regs.svh
// register offsets, field positions, reset values and timing counts
// assumes a byte-addressed register port with 32-bit data words
`ifndef TSM_REGS_SVH
`define TSM_REGS_SVH
`define TSM_A_BEGIN_RX   12'h000
`define TSM_A_BEGIN_TX   12'h008
`define TSM_A_STOP       12'h014
`define TSM_A_EV_HALT    12'h104
`define TSM_A_EV_RCV     12'h108
`define TSM_A_EV_SENT    12'h11c
`define TSM_A_EV_ERR     12'h124
`define TSM_A_SHORTS     12'h200
`define TSM_A_ENABLE     12'h500
`define TSM_A_PSEL_SCL   12'h508
`define TSM_A_PSEL_SDA   12'h50c
`define TSM_A_RXD        12'h518
`define TSM_A_TXD        12'h51c
`define TSM_A_RATE       12'h524
`define TSM_A_ADDRESS    12'h588
`define TSM_EV_HALT      0
`define TSM_EV_RCV       1
`define TSM_EV_SENT      2
`define TSM_EV_ERR       3
`define TSM_PSEL_OFF_BIT 31
`define TSM_PSEL_RST     32'h80000000
`define TSM_SH_SENT_STOP 0
`define TSM_SH_RCV_STOP  1
`define TSM_LAST_BIT     4'h7
`define TSM_ACK_BIT      4'h8
`define TSM_CLK_HZ       100000000
`define TSM_STD_HZ       100000
`define TSM_FAST_HZ      400000
`define TSM_QTR(hz)      (`TSM_CLK_HZ / (4 * (hz)))
`endif

// File: tsm_pkg.sv
// types shared by the two-wire master
// assumes tsm_regs.svh supplies the numeric constants
package tsm_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_START = 3'b001,
		ST_XFER  = 3'b010,
		ST_NEXT  = 3'b011,
		ST_STOP  = 3'b100
	} tsm_state_e;
	typedef logic [1:0] tsm_phase_t;
endpackage

// File: tsm_two_wire_master.sv
// two_wire_master: single-buffered byte engine for a two-wire bus
// assumes open-drain pads resolved outside, pins sampled asynchronously
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ns
`include "tsm_regs.svh"
module tsm_two_wire_master #(
	parameter int NPIN  = 4,
	parameter int PIN_W = 2
) (
	input  wire logic              ref_clk,   // core clock, 100 MHz
	input  wire logic              resetn,    // async reset, active low
	input  wire logic [11:0]       reg_addr,  // byte address
	input  wire logic [31:0]       reg_wdata, // write data
	input  wire logic              reg_we,    // write strobe
	input  wire logic              reg_re,    // read strobe
	output logic      [31:0]       reg_rdata, // read data, one cycle later
	input  wire logic [NPIN-1:0]   gpio_in,   // pad levels
	output logic      [NPIN-1:0]   gpio_out,  // pad output value, always low
	output logic      [NPIN-1:0]   gpio_oe    // pad pulled low when high
);
	localparam logic [7:0] Q_STD  = 8'(`TSM_QTR(`TSM_STD_HZ));
	localparam logic [7:0] Q_FAST = 8'(`TSM_QTR(`TSM_FAST_HZ));

	// refuse pin maps the select field cannot reach, at elaboration
	if (NPIN < 1 || NPIN > (1 << PIN_W) || PIN_W > 30) begin
		$error("tsm_two_wire_master: bad NPIN or PIN_W");
	end

	function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
		hit = (a == o);
	endfunction

	// disconnected or unselected lines float high
	function automatic logic pin_level(input logic [NPIN-1:0] lv,
	                                   input logic [31:0] sel);
		pin_level = 1'b1;
		if (!sel[`TSM_PSEL_OFF_BIT] && 32'(sel[PIN_W-1:0]) < NPIN)
			pin_level = lv[sel[PIN_W-1:0]];
	endfunction

	logic [31:0]          psel_scl_q;
	logic [31:0]          psel_sda_q;
	logic                 enable_q;
	logic                 rate_q;
	logic [6:0]           address_q;
	logic [1:0]           shorts_q;
	logic [7:0]           tx_q;
	logic                 tx_full_q;
	logic [7:0]           rxd_q;
	logic                 rx_full_q;
	logic [3:0]           ev_q;
	logic                 stop_pend_q;
	logic                 start_pend_q;
	logic                 start_rx_q;
	logic [NPIN-1:0]      s1_q;
	logic [NPIN-1:0]      s2_q;
	logic [NPIN-1:0]      s3_q;
	logic [NPIN-1:0]      filt_q;
	logic [7:0]           div_q;
	logic                 tick;
	logic                 scl_in;
	logic                 sda_in;
	tsm_pkg::tsm_state_e  state_q;
	tsm_pkg::tsm_phase_t  ph_q;
	logic                 scl_lo_q;
	logic                 sda_lo_q;
	logic [7:0]           sh_q;
	logic [3:0]           bit_q;
	logic                 rx_q;
	logic                 addr_ph_q;
	logic                 nack_tx_q;
	logic [3:0]           ev_set_q;
	logic                 tx_take_q;
	logic                 rx_load_q;
	logic                 clr_stop_q;
	logic                 clr_start_q;
	logic                 rxdata;
	logic                 short_ok;

	// three-stage pin sampling; a change counts when stages two and three agree
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			s1_q   <= '1;
			s2_q   <= '1;
			s3_q   <= '1;
			filt_q <= '1;
		end else begin
			s1_q <= gpio_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			for (int i = 0; i < NPIN; i++) begin
				if (s2_q[i] == s3_q[i])
					filt_q[i] <= s3_q[i];
			end
		end
	end

	assign scl_in = pin_level(filt_q, psel_scl_q);
	assign sda_in = pin_level(filt_q, psel_sda_q);

	// quarter-bit divider; the rate bit picks standard or fast
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			div_q <= 8'h00;
		else if (!enable_q || div_q == 8'h00)
			div_q <= (rate_q ? Q_FAST : Q_STD) - 8'h01;
		else
			div_q <= div_q - 8'h01;
	end
	assign tick = enable_q && (div_q == 8'h00);

	// configuration registers; disabling clears nothing so software
	// must reprogram whatever another user may have left behind
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			enable_q   <= 1'b0;
			rate_q     <= 1'b0;
			address_q  <= 7'h00;
			shorts_q   <= 2'h0;
			psel_scl_q <= `TSM_PSEL_RST;
			psel_sda_q <= `TSM_PSEL_RST;
		end else if (reg_we) begin
			if (hit(reg_addr, `TSM_A_ENABLE))
				enable_q <= reg_wdata[0];
			if (hit(reg_addr, `TSM_A_RATE))
				rate_q <= reg_wdata[0];
			if (hit(reg_addr, `TSM_A_ADDRESS))
				address_q <= reg_wdata[6:0];
			if (hit(reg_addr, `TSM_A_SHORTS))
				shorts_q <= reg_wdata[1:0];
			if (hit(reg_addr, `TSM_A_PSEL_SCL))
				psel_scl_q <= reg_wdata;
			if (hit(reg_addr, `TSM_A_PSEL_SDA))
				psel_sda_q <= reg_wdata;
		end
	end

	// single-byte transmit holder, freed when the engine takes it
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			tx_q      <= 8'h00;
			tx_full_q <= 1'b0;
		end else if (reg_we && hit(reg_addr, `TSM_A_TXD)) begin
			tx_q      <= reg_wdata[7:0];
			tx_full_q <= 1'b1;
		end else if (tx_take_q) begin
			tx_full_q <= 1'b0;
		end
	end

	// receive full flag: a read frees it, a new byte wins over the read
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			rx_full_q <= 1'b0;
		else if (rx_load_q)
			rx_full_q <= 1'b1;
		else if (reg_re && hit(reg_addr, `TSM_A_RXD))
			rx_full_q <= 1'b0;
	end

	// both stop shortcuts on at once is treated as none
	assign short_ok = (shorts_q != 2'h3);

	// pending tasks; a task in the cycle of its clear still counts
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			stop_pend_q  <= 1'b0;
			start_pend_q <= 1'b0;
			start_rx_q   <= 1'b0;
		end else begin
			if (reg_we && reg_wdata[0] && hit(reg_addr, `TSM_A_STOP))
				stop_pend_q <= 1'b1;
			else if (short_ok && ev_set_q[`TSM_EV_SENT] &&
			         shorts_q[`TSM_SH_SENT_STOP])
				stop_pend_q <= 1'b1;
			else if (short_ok && ev_set_q[`TSM_EV_RCV] &&
			         shorts_q[`TSM_SH_RCV_STOP])
				stop_pend_q <= 1'b1;
			else if (clr_stop_q || !enable_q)
				stop_pend_q <= 1'b0;
			if (reg_we && reg_wdata[0] && hit(reg_addr, `TSM_A_BEGIN_RX)) begin
				start_pend_q <= 1'b1;
				start_rx_q   <= 1'b1;
			end else if (reg_we && reg_wdata[0] &&
			             hit(reg_addr, `TSM_A_BEGIN_TX)) begin
				start_pend_q <= 1'b1;
				start_rx_q   <= 1'b0;
			end else if (clr_start_q || !enable_q) begin
				start_pend_q <= 1'b0;
			end
		end
	end

	// sticky events, cleared by writing zero; a set in the same cycle wins
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			ev_q <= 4'h0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (ev_set_q[i])
					ev_q[i] <= 1'b1;
				else if (reg_we && !reg_wdata[0] &&
				         ((i == `TSM_EV_HALT && hit(reg_addr, `TSM_A_EV_HALT)) ||
				          (i == `TSM_EV_RCV  && hit(reg_addr, `TSM_A_EV_RCV)) ||
				          (i == `TSM_EV_SENT && hit(reg_addr, `TSM_A_EV_SENT)) ||
				          (i == `TSM_EV_ERR  && hit(reg_addr, `TSM_A_EV_ERR))))
					ev_q[i] <= 1'b0;
			end
		end
	end

	// read port: data stand only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 32'h00000000;
		end else if (!reg_re) begin
			reg_rdata <= 32'h00000000;
		end else begin
			case (reg_addr)
			`TSM_A_EV_HALT:  reg_rdata <= {31'h0, ev_q[`TSM_EV_HALT]};
			`TSM_A_EV_RCV:   reg_rdata <= {31'h0, ev_q[`TSM_EV_RCV]};
			`TSM_A_EV_SENT:  reg_rdata <= {31'h0, ev_q[`TSM_EV_SENT]};
			`TSM_A_EV_ERR:   reg_rdata <= {31'h0, ev_q[`TSM_EV_ERR]};
			`TSM_A_SHORTS:   reg_rdata <= {30'h0, shorts_q};
			`TSM_A_ENABLE:   reg_rdata <= {31'h0, enable_q};
			`TSM_A_PSEL_SCL: reg_rdata <= psel_scl_q;
			`TSM_A_PSEL_SDA: reg_rdata <= psel_sda_q;
			`TSM_A_RXD:      reg_rdata <= {24'h0, rxd_q};
			`TSM_A_TXD:      reg_rdata <= {24'h0, tx_q};
			`TSM_A_RATE:     reg_rdata <= {31'h0, rate_q};
			`TSM_A_ADDRESS:  reg_rdata <= {25'h0, address_q};
			default:         reg_rdata <= 32'h00000000;
			endcase
		end
	end

	assign rxdata = rx_q && !addr_ph_q;

	// bus engine: four quarters per bit, scl low in quarters 0-1;
	// the engine never looks for other masters on the wire
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q     <= tsm_pkg::ST_IDLE;
			ph_q        <= 2'h0;
			scl_lo_q    <= 1'b0;
			sda_lo_q    <= 1'b0;
			sh_q        <= 8'h00;
			bit_q       <= 4'h0;
			rx_q        <= 1'b0;
			addr_ph_q   <= 1'b0;
			nack_tx_q   <= 1'b0;
			rxd_q       <= 8'h00;
			ev_set_q    <= 4'h0;
			tx_take_q   <= 1'b0;
			rx_load_q   <= 1'b0;
			clr_stop_q  <= 1'b0;
			clr_start_q <= 1'b0;
		end else begin
			ev_set_q    <= 4'h0;
			tx_take_q   <= 1'b0;
			rx_load_q   <= 1'b0;
			clr_stop_q  <= 1'b0;
			clr_start_q <= 1'b0;
			if (!enable_q) begin
				state_q  <= tsm_pkg::ST_IDLE;
				ph_q     <= 2'h0;
				scl_lo_q <= 1'b0;
				sda_lo_q <= 1'b0;
			end else if (tick) begin
				case (state_q)
				tsm_pkg::ST_IDLE: begin
					if (start_pend_q) begin
						state_q     <= tsm_pkg::ST_START;
						ph_q        <= 2'h0;
						rx_q        <= start_rx_q;
						clr_start_q <= 1'b1;
					end else if (stop_pend_q) begin
						clr_stop_q <= 1'b1;
						ev_set_q[`TSM_EV_HALT] <= 1'b1;
					end
				end
				tsm_pkg::ST_START: begin
					case (ph_q)
					2'h0: begin
						sda_lo_q <= 1'b0;
						ph_q     <= 2'h1;
					end
					2'h1: begin
						scl_lo_q <= 1'b0;
						ph_q     <= 2'h2;
					end
					2'h2: begin
						if (scl_in) begin
							sda_lo_q <= 1'b1;
							ph_q     <= 2'h3;
						end
					end
					default: begin
						scl_lo_q  <= 1'b1;
						sh_q      <= {address_q, rx_q};
						bit_q     <= 4'h0;
						addr_ph_q <= 1'b1;
						state_q   <= tsm_pkg::ST_XFER;
						ph_q      <= 2'h0;
					end
					endcase
				end
				tsm_pkg::ST_XFER: begin
					case (ph_q)
					2'h0: begin
						if (bit_q == `TSM_ACK_BIT && rxdata) begin
							if (!rx_full_q) begin
								sda_lo_q  <= !(stop_pend_q || start_pend_q);
								nack_tx_q <= stop_pend_q || start_pend_q;
								ph_q      <= 2'h1;
							end
						end else begin
							sda_lo_q <= (bit_q != `TSM_ACK_BIT) && !rxdata &&
							            !sh_q[7];
							ph_q     <= 2'h1;
						end
					end
					2'h1: begin
						scl_lo_q <= 1'b0;
						ph_q     <= 2'h2;
					end
					2'h2: begin
						if (scl_in)
							ph_q <= 2'h3;
					end
					default: begin
						scl_lo_q <= 1'b1;
						ph_q     <= 2'h0;
						if (bit_q != `TSM_ACK_BIT) begin
							sh_q  <= {sh_q[6:0], sda_in};
							bit_q <= bit_q + 4'h1;
							if (bit_q == `TSM_LAST_BIT && rxdata) begin
								rxd_q     <= {sh_q[6:0], sda_in};
								rx_load_q <= 1'b1;
								ev_set_q[`TSM_EV_RCV] <= 1'b1;
							end
						end else begin
							if (!rxdata && sda_in)
								ev_set_q[`TSM_EV_ERR] <= 1'b1;
							if (!rx_q && !addr_ph_q)
								ev_set_q[`TSM_EV_SENT] <= 1'b1;
							state_q <= tsm_pkg::ST_NEXT;
						end
					end
					endcase
				end
				tsm_pkg::ST_NEXT: begin
					// scl stays low here until there is work to do
					if (rxdata && !nack_tx_q) begin
						state_q <= tsm_pkg::ST_XFER;
						bit_q   <= 4'h0;
					end else if (stop_pend_q) begin
						state_q   <= tsm_pkg::ST_STOP;
						nack_tx_q <= 1'b0;
					end else if (start_pend_q) begin
						state_q     <= tsm_pkg::ST_START;
						rx_q        <= start_rx_q;
						clr_start_q <= 1'b1;
						nack_tx_q   <= 1'b0;
					end else if (rx_q && addr_ph_q) begin
						state_q   <= tsm_pkg::ST_XFER;
						addr_ph_q <= 1'b0;
						bit_q     <= 4'h0;
					end else if (!rx_q && tx_full_q) begin
						sh_q      <= tx_q;
						tx_take_q <= 1'b1;
						addr_ph_q <= 1'b0;
						bit_q     <= 4'h0;
						state_q   <= tsm_pkg::ST_XFER;
					end
					ph_q <= 2'h0;
				end
				tsm_pkg::ST_STOP: begin
					case (ph_q)
					2'h0: begin
						sda_lo_q <= 1'b1;
						ph_q     <= 2'h1;
					end
					2'h1: begin
						scl_lo_q <= 1'b0;
						ph_q     <= 2'h2;
					end
					2'h2: begin
						if (scl_in)
							ph_q <= 2'h3;
					end
					default: begin
						sda_lo_q   <= 1'b0;
						clr_stop_q <= 1'b1;
						ev_set_q[`TSM_EV_HALT] <= 1'b1;
						state_q    <= tsm_pkg::ST_IDLE;
						ph_q       <= 2'h0;
					end
					endcase
				end
				default: begin
					state_q <= tsm_pkg::ST_IDLE;
					ph_q    <= 2'h0;
				end
				endcase
			end
		end
	end

	// pad drive; a selected pin is pulled low only while enabled
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			gpio_oe  <= '0;
			gpio_out <= '0;
		end else begin
			gpio_out <= '0;
			for (int p = 0; p < NPIN; p++) begin
				gpio_oe[p] <= enable_q && (
				  (scl_lo_q && !psel_scl_q[`TSM_PSEL_OFF_BIT] &&
				   32'(psel_scl_q[PIN_W-1:0]) == p) ||
				  (sda_lo_q && !psel_sda_q[`TSM_PSEL_OFF_BIT] &&
				   32'(psel_sda_q[PIN_W-1:0]) == p));
			end
		end
	end
endmodule

// File: tsm_two_wire_master_monitor.sv
// port checker for the two-wire master
// assumes open-drain pads with pull-ups resolved outside the block
`timescale 1ns/1ns
`include "tsm_regs.svh"
module tsm_two_wire_master_monitor #(
	parameter int NPIN  = 4,
	parameter int PIN_W = 2
) (
	input wire logic            ref_clk,   // core clock
	input wire logic            resetn,    // async reset, active low
	input wire logic [11:0]     reg_addr,  // byte address
	input wire logic [31:0]     reg_wdata, // write data
	input wire logic            reg_we,    // write strobe
	input wire logic            reg_re,    // read strobe
	input wire logic [31:0]     reg_rdata, // read data
	input wire logic [NPIN-1:0] gpio_in,   // pad levels
	input wire logic [NPIN-1:0] gpio_out,  // pad output value
	input wire logic [NPIN-1:0] gpio_oe    // pad pulled low when high
);
	logic [31:0]     scl_sel_q;
	logic [31:0]     sda_sel_q;
	logic            en_q;
	logic [8:0]      lo_cnt_q;
	logic [NPIN-1:0] used;
	logic            scl_in;
	logic            sda_in;
	logic            scl_oe;
	logic            sda_oe;
	// pads seen through the selects that software wrote
	assign scl_in = gpio_in[scl_sel_q[PIN_W-1:0]];
	assign sda_in = gpio_in[sda_sel_q[PIN_W-1:0]];
	assign scl_oe = gpio_oe[scl_sel_q[PIN_W-1:0]];
	assign sda_oe = gpio_oe[sda_sel_q[PIN_W-1:0]];
	// shadow copies of enable and pin selects
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			scl_sel_q <= `TSM_PSEL_RST;
			sda_sel_q <= `TSM_PSEL_RST;
			en_q      <= 1'b0;
		end else if (reg_we) begin
			if (reg_addr == `TSM_A_PSEL_SCL) scl_sel_q <= reg_wdata;
			if (reg_addr == `TSM_A_PSEL_SDA) sda_sel_q <= reg_wdata;
			if (reg_addr == `TSM_A_ENABLE) en_q <= reg_wdata[0];
		end
	end
	// pins a connected select points at
	always_comb begin
		used = '0;
		if (!scl_sel_q[`TSM_PSEL_OFF_BIT]) used[scl_sel_q[PIN_W-1:0]] = 1'b1;
		if (!sda_sel_q[`TSM_PSEL_OFF_BIT]) used[sda_sel_q[PIN_W-1:0]] = 1'b1;
	end
	// length of the low phase the block drives; saturates, never wraps
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			lo_cnt_q <= 9'h000;
		end else if (!scl_oe) begin
			lo_cnt_q <= 9'h000;
		end else if (lo_cnt_q != 9'h1ff) begin
			lo_cnt_q <= lo_cnt_q + 9'h001;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	sequence s_start;
		$fell(sda_in) && scl_in;
	endsequence
	sequence s_stop;
		$rose(sda_in) && scl_in;
	endsequence
	AST_PIN_UNUSED: assert property ((gpio_oe & ~used) == '0)
		else $error("pad pulled on an unselected pin");
	AST_OFF_QUIET: assert property (!en_q [*3] |-> gpio_oe == '0)
		else $error("pad pulled while disabled");
	AST_OPEN_DRAIN: assert property (gpio_out == '0)
		else $error("pad driven high");
	AST_STRETCH: assert property ((!scl_oe && !scl_in) [*8] |=> !scl_oe)
		else $error("clock pulled during a slave hold");
	AST_LOW_PHASE: assert property ($fell(scl_oe) |-> lo_cnt_q >= 9'h03c)
		else $error("clock low phase too short");
	AST_START_CLK: assert property (s_start |-> sda_oe throughout
		(##[1:300] scl_oe))
		else $error("start not followed by clock low");
	AST_STOP_IDLE: assert property (s_stop |-> (gpio_oe == '0) [*8])
		else $error("lines not released after stop");
	AST_READ_BLANK: assert property (!$past(reg_re) |-> reg_rdata == '0)
		else $error("read data outside its cycle");
endmodule
bind tsm_two_wire_master tsm_two_wire_master_monitor #(.NPIN(NPIN),
	.PIN_W(PIN_W)) u_mon (.ref_clk(ref_clk), .resetn(resetn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
	.reg_re(reg_re), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe));

// File: tsm_slave_model.sv
// behavioural slave: acks its address, takes writes, returns a byte
// assumes both wires resolved as pulled-up open-drain lines
`timescale 1ns/1ns
module tsm_slave_model #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	input  wire logic       scl,     // resolved clock line
	input  wire logic       sda,     // resolved data line
	input  wire logic [7:0] rd_byte, // byte handed back on reads
	input  wire logic       stretch, // hold the clock after each byte
	output logic            scl_oe,  // pulls clock low when high
	output logic            sda_oe,  // pulls data low when high
	output logic [7:0]      got,     // last address or write byte
	output int              n_start, // starts seen
	output int              n_stop   // stops seen
);
	logic [7:0] sh;
	logic [7:0] txb;
	logic       sel;
	logic       rd;
	logic       adr_ph;
	logic       mnack;
	int         bitn;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
		n_start = 0;
		n_stop = 0;
		bitn = 0;
		sel = 1'b0;
		rd = 1'b0;
		adr_ph = 1'b0;
		mnack = 1'b0;
		txb = 8'h00;
	end
	// start or repeated start
	always @(negedge sda) begin
		if (scl === 1'b1) begin
			n_start++;
			bitn = 0;
			adr_ph = 1'b1;
			sel = 1'b0;
		end
	end
	always @(posedge sda) begin
		if (scl === 1'b1) n_stop++;
	end
	// sample on the rising clock; slot 8 carries the acknowledge
	always @(posedge scl) begin
		if (bitn < 8) sh = {sh[6:0], sda};
		else mnack = sda;
		bitn++;
	end
	// change data only while the clock is low
	always @(negedge scl) begin
		sda_oe = 1'b0;
		if (bitn == 8) begin
			if (adr_ph | ~rd) got = sh;
			if (adr_ph) begin
				sel = (sh[7:1] == ADDR);
				rd = sh[0];
			end
			sda_oe = sel & (adr_ph | ~rd);
			adr_ph = 1'b0;
		end else if (bitn == 9) begin
			bitn = 0;
			txb = rd_byte;
			if (rd & mnack) sel = 1'b0;  // not-ack ends the read
			sda_oe = sel & rd & ~txb[7];
		end else if (bitn > 0 && bitn < 8) begin
			sda_oe = sel & rd & ~adr_ph & ~txb[7-bitn];
		end
		if (stretch && bitn == 8) begin
			scl_oe = 1'b1;
			#2000;
			scl_oe = 1'b0;
		end
	end
endmodule

// File: testbench.sv
// self-checking bench for the two-wire master with one slave
// assumes scl on pad 0, sda on pad 1, pads pulled up
`timescale 1ns/1ns
`include "tsm_regs.svh"
module testbench;
	localparam logic [6:0] SLV = 7'h2a;
	logic        ref_clk;
	logic        resetn;
	logic        reg_we;
	logic        reg_re;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata;
	logic [31:0] reg_rdata;
	logic [31:0] v;
	logic [3:0]  gpio_in;
	logic [3:0]  gpio_out;
	logic [3:0]  gpio_oe;
	logic        scl_oe;
	logic        sda_oe;
	logic        stretch;
	logic [7:0]  rd_byte;
	logic [7:0]  got;
	int          n_start;
	int          n_stop;
	int          fails;
	int          n_compared;
	int          cyc;
	wire         scl = ~(gpio_oe[0] | scl_oe);
	wire         sda = ~(gpio_oe[1] | sda_oe);
	assign gpio_in = {2'b11, sda, scl};  // idle pads float high
	tsm_two_wire_master dut (.ref_clk(ref_clk), .resetn(resetn),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe));
	tsm_slave_model #(.ADDR(SLV)) slave (.scl(scl), .sda(sda),
		.rd_byte(rd_byte), .stretch(stretch), .scl_oe(scl_oe),
		.sda_oe(sda_oe), .got(got), .n_start(n_start), .n_stop(n_stop));
	always #5 ref_clk = ~ref_clk;
	task automatic complete_run;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] act);
		n_compared++;
		if (act !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, act);
		end
	endtask
	// one-cycle strobes, an idle edge after each
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge ref_clk);
		reg_we <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge ref_clk);
		reg_re <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
		@(posedge ref_clk);
	endtask
	// poll an event until set, then clear it
	task automatic ev_wait(input logic [11:0] a);
		v = 32'h0;
		// a whole std-rate address frame plus stop needs about 12k cycles
		for (int i = 0; i < 6000 && v !== 32'h1; i++) rd(a, v);
		chk("event", 32'h1, v);
		wr(a, 32'h0);
	endtask
	task automatic setup(input logic [6:0] a);
		wr(`TSM_A_ENABLE, 32'h0);
		wr(`TSM_A_PSEL_SCL, 32'h0);
		wr(`TSM_A_PSEL_SDA, 32'h1);
		wr(`TSM_A_RATE, 32'h1);
		wr(`TSM_A_ADDRESS, {25'h0, a});
		wr(`TSM_A_SHORTS, 32'h0);
		wr(`TSM_A_ENABLE, 32'h1);
	endtask
	// the sda select reset value, an unmapped place, disconnected pins left alone
	task automatic t_regs;
		rd(`TSM_A_PSEL_SDA, v);
		chk("sda select", `TSM_PSEL_RST, v);
		rd(12'h7fc, v);
		chk("unmapped", 32'h0, v);
		wr(`TSM_A_ENABLE, 32'h1);
		wr(`TSM_A_BEGIN_TX, 32'h1);
		repeat (3000) @(posedge ref_clk);
		chk("pads", 32'h0, {28'h0, gpio_oe});
		wr(`TSM_A_STOP, 32'h1);
		ev_wait(`TSM_A_EV_HALT);
		rd(`TSM_A_EV_ERR, v);
		chk("error", 32'h1, v);
		wr(`TSM_A_EV_ERR, 32'h0);
	endtask
	// write with a late first byte, two bytes, then stop
	task automatic t_write;
		int p;
		p = n_stop;
		setup(SLV);
		wr(`TSM_A_BEGIN_TX, 32'h1);
		repeat (4000) @(posedge ref_clk);  // past start and address
		chk("scl held", 32'h1, {31'h0, gpio_oe[0]});
		chk("address", {24'h0, SLV, 1'b0}, {24'h0, got});
		chk("pad value", 32'h0, {28'h0, gpio_out});
		wr(`TSM_A_TXD, 32'ha5);
		ev_wait(`TSM_A_EV_SENT);
		chk("byte", 32'ha5, {24'h0, got});
		wr(`TSM_A_TXD, 32'h3c);  // only after the sent event
		ev_wait(`TSM_A_EV_SENT);
		chk("byte", 32'h3c, {24'h0, got});
		wr(`TSM_A_STOP, 32'h1);
		ev_wait(`TSM_A_EV_HALT);
		chk("stops", p + 1, n_stop);
		chk("released", 32'h0, {28'h0, gpio_oe});
	endtask
	// two-byte read with a stretching slave
	task automatic t_read;
		int p;
		p = n_stop;
		setup(SLV);
		stretch <= 1'b1;
		rd_byte <= 8'h96;
		wr(`TSM_A_BEGIN_RX, 32'h1);
		ev_wait(`TSM_A_EV_RCV);
		chk("address", {24'h0, SLV, 1'b1}, {24'h0, got});
		repeat (500) @(posedge ref_clk);
		chk("scl held", 32'h1, {31'h0, gpio_oe[0]});
		rd_byte <= 8'h4b;
		rd(`TSM_A_RXD, v);
		chk("rx byte", 32'h96, v);
		ev_wait(`TSM_A_EV_RCV);
		wr(`TSM_A_STOP, 32'h1);
		rd(`TSM_A_RXD, v);
		chk("rx byte", 32'h4b, v);
		ev_wait(`TSM_A_EV_HALT);
		chk("stops", p + 1, n_stop);
		stretch <= 1'b0;
	endtask
	// nobody answers this address
	task automatic t_nack;
		setup(7'h11);
		wr(`TSM_A_BEGIN_TX, 32'h1);
		ev_wait(`TSM_A_EV_ERR);
		wr(`TSM_A_STOP, 32'h1);
		ev_wait(`TSM_A_EV_HALT);
	endtask
	// read, repeated start into a write, stop by the sent shortcut
	task automatic t_rstart;
		int s;
		int p;
		s = n_start;
		p = n_stop;
		setup(SLV);
		rd_byte <= 8'hc3;
		wr(`TSM_A_BEGIN_RX, 32'h1);
		ev_wait(`TSM_A_EV_RCV);
		wr(`TSM_A_BEGIN_TX, 32'h1);
		rd(`TSM_A_RXD, v);
		chk("rx byte", 32'hc3, v);
		wr(`TSM_A_SHORTS, 32'h1);
		wr(`TSM_A_TXD, 32'h5a);
		ev_wait(`TSM_A_EV_SENT);
		chk("byte", 32'h5a, {24'h0, got});
		ev_wait(`TSM_A_EV_HALT);
		chk("starts", s + 2, n_start);
		chk("stops", p + 1, n_stop);
	endtask
	// cut a hang short well past the expected run length
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			fails++;
			complete_run;
		end
	end
	initial begin
		ref_clk = 1'b0;
		resetn = 1'b0;
		reg_we = 1'b0;
		reg_re = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h0;
		stretch = 1'b0;
		rd_byte = 8'h00;
		fails = 0;
		n_compared = 0;
		cyc = 0;
		repeat (5) @(posedge ref_clk);
		resetn <= 1'b1;
		@(posedge ref_clk);
		t_regs;
		t_write;
		t_read;
		t_nack;
		t_rstart;
		complete_run;
	end
endmodule
